//--- core/sls_top.sv
// front panel status led sequencer with axi4-lite register slave
//
// How it works
// - drive eighteen leds, two device, sixteen channel
// - power-up starts with both device leds lit
// - red leds light cumulatively, channel one to eight
// - then red leds go dark one by one
// - same on-then-off sweep over amber leds
// - red leds show captured address switch bits
// - address pattern held for two seconds
// - device fault led off after address display
// - unconfigured module blinks all amber leds together
// - green power led always lit
// - amber device led steady when disabled/watchdog
// - amber device led blinks once at power-up
// - discrete type: red steady when channel active
// - amber blinks on low power or unconfigured channel, except for the spare type
// - discrete type: amber steady on channel fault
// - relay: red steady when active, no steady amber
// - analog type: red blinks low, steady high alarm
// - analog type: amber steady when out of range
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module sls_top #(
    parameter int unsigned ADDR_SHOW_CYCLES = sls_pkg::ADDR_SHOW_CYC,
    parameter int unsigned STEP_CYCLES = sls_pkg::STEP_CYC,
    parameter int unsigned BLINK_HALF_CYCLES = sls_pkg::BLINK_HALF_CYC
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR_SW,
    input wire logic WDOG_FAULT,
    output logic LED_PWR,
    output logic LED_FLT,
    output logic [7:0] LED_ACT,
    output logic [7:0] LED_CFLT,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    sls_pkg::sls_state_s s;
    sls_pkg::sls_state_s n;
    logic tmr_end;
    logic [7:0] sweep_mask;
    logic [7:0] warn;

    // register read mux; unmapped words read zero with slverr
    function automatic logic [33:0] rd_word(input sls_pkg::sls_state_s st, input logic [7:0] a);
        logic [7:0] wa;
        wa = {a[7:2], 2'h0};
        unique case (wa)
            sls_pkg::OFS_CTRL: rd_word = {sls_pkg::RESP_OKAY, 27'h0, st.low_pwr, st.dev_dis, st.mod_cfg, st.mtype};
            sls_pkg::OFS_CH_ACT: rd_word = {sls_pkg::RESP_OKAY, 24'h0, st.ch_act};
            sls_pkg::OFS_CH_FLT: rd_word = {sls_pkg::RESP_OKAY, 24'h0, st.ch_flt};
            sls_pkg::OFS_CH_LOW: rd_word = {sls_pkg::RESP_OKAY, 24'h0, st.ch_low};
            sls_pkg::OFS_CH_CFG: rd_word = {sls_pkg::RESP_OKAY, 24'h0, st.ch_cfg};
            sls_pkg::OFS_STATUS: rd_word = {sls_pkg::RESP_OKAY, 20'h0, st.cap_done, st.addr, st.phase};
            sls_pkg::OFS_LEDS: rd_word = {sls_pkg::RESP_OKAY, 14'h0, st.led_pwr, st.led_flt, st.led_cflt, st.led_act};
            default: rd_word = {sls_pkg::RESP_SLVERR, 32'h0};
        endcase
    endfunction

    // cumulative sweep mask: channels up to the current step index
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            sweep_mask[k] = (3'(k) <= s.idx);
        end
    end

    // timer end depends on phase; address display uses its own long count
    assign tmr_end = (s.phase == sls_pkg::PH_ADDR) ? (s.tmr == 32'(ADDR_SHOW_CYCLES - 1))
                                                    : (s.tmr == 32'(STEP_CYCLES - 1));

    // per-channel blink request: low power or channel lacks configuration
    assign warn = {8{s.low_pwr}} | ~s.ch_cfg;

    // next-state logic: sequencer, blink, register slave and led drive
    always_comb begin
        logic [33:0] rw;
        rw = '0;
        n = s;

        // address switches caught on the first edge after release only
        if (!s.cap_done) begin
            n.addr = ADDR_SW;
            n.cap_done = 1'h1;
        end

        // free running blink; one common phase for every channel
        if (s.blink_tmr == 32'(BLINK_HALF_CYCLES - 1)) begin
            n.blink_tmr = '0;
            n.blink = ~s.blink;
        end else begin
            n.blink_tmr = s.blink_tmr + 32'h1;
        end

        // power-up sequencer
        if (s.phase != sls_pkg::PH_RUN) begin
            n.tmr = tmr_end ? 32'h0 : s.tmr + 32'h1;
        end
        if (tmr_end) begin
            unique case (s.phase)
                sls_pkg::PH_LAMP: n.phase = sls_pkg::PH_RED_ON;
                sls_pkg::PH_RED_ON, sls_pkg::PH_RED_OFF, sls_pkg::PH_AMB_ON, sls_pkg::PH_AMB_OFF: begin
                    n.idx = s.idx + 3'h1;
                    if (s.idx == 3'h7) begin
                        n.phase = sls_pkg::sls_phase_e'(s.phase + 3'h1);
                    end
                end
                sls_pkg::PH_ADDR: n.phase = sls_pkg::PH_RUN;
                sls_pkg::PH_RUN: n.phase = sls_pkg::PH_RUN;
                default: n.phase = sls_pkg::PH_RUN;
            endcase
        end

        // axi write: address and data taken in either order
        if (S_AXI_AWVALID && s.awready) begin
            n.aw_got = 1'h1;
            n.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && s.wready) begin
            n.w_got = 1'h1;
            n.wdata = S_AXI_WDATA[7:0];
            n.wstb = S_AXI_WSTRB[0];
        end
        if (s.bvalid && S_AXI_BREADY) begin
            n.bvalid = 1'h0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'h0;
            n.w_got = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = sls_pkg::RESP_OKAY;
            if (s.wstb) begin
                unique case ({s.awaddr[7:2], 2'h0})
                    sls_pkg::OFS_CTRL: begin
                        n.mtype = sls_pkg::sls_mtype_e'(s.wdata[sls_pkg::CTRL_TYPE_LSB +: 2]);
                        n.mod_cfg = s.wdata[sls_pkg::CTRL_CFG_BIT];
                        n.dev_dis = s.wdata[sls_pkg::CTRL_DIS_BIT];
                        n.low_pwr = s.wdata[sls_pkg::CTRL_LOWPWR_BIT];
                    end
                    sls_pkg::OFS_CH_ACT: n.ch_act = s.wdata;
                    sls_pkg::OFS_CH_FLT: n.ch_flt = s.wdata;
                    sls_pkg::OFS_CH_LOW: n.ch_low = s.wdata;
                    sls_pkg::OFS_CH_CFG: n.ch_cfg = s.wdata;
                    sls_pkg::OFS_STATUS, sls_pkg::OFS_LEDS: n.bresp = sls_pkg::RESP_OKAY;
                    default: n.bresp = sls_pkg::RESP_SLVERR;
                endcase
            end else if (rd_word(s, s.awaddr) >> 32 != 34'h0) begin
                n.bresp = sls_pkg::RESP_SLVERR;
            end
        end
        // ready drops while a word is held so nothing is overwritten
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;

        // axi read: one outstanding, data latched at the address edge
        if (s.rvalid && S_AXI_RREADY) begin
            n.rvalid = 1'h0;
        end
        if (S_AXI_ARVALID && s.arready) begin
            rw = rd_word(s, S_AXI_ARADDR);
            n.rvalid = 1'h1;
            n.rdata = rw[31:0];
            n.rresp = rw[33:32];
        end
        n.arready = !n.rvalid;

        // led drive; green stays lit from reset onward
        n.led_pwr = sls_pkg::LED_ON;
        n.led_flt = 1'h0;
        n.led_act = 8'h0;
        n.led_cflt = 8'h0;
        unique case (s.phase)
            sls_pkg::PH_LAMP: n.led_flt = 1'h1;
            sls_pkg::PH_RED_ON: begin
                n.led_flt = 1'h1;
                n.led_act = sweep_mask;
            end
            sls_pkg::PH_RED_OFF: begin
                n.led_flt = 1'h1;
                n.led_act = ~sweep_mask;
            end
            sls_pkg::PH_AMB_ON: begin
                n.led_flt = 1'h1;
                n.led_cflt = sweep_mask;
            end
            sls_pkg::PH_AMB_OFF: begin
                n.led_flt = 1'h1;
                n.led_cflt = ~sweep_mask;
            end
            sls_pkg::PH_ADDR: begin
                n.led_flt = 1'h1;
                n.led_act = s.addr;
            end
            sls_pkg::PH_RUN: begin
                // the one power-up blink ends here; afterwards only faults light it
                n.led_flt = s.dev_dis | WDOG_FAULT;
                if (!s.mod_cfg) begin
                    n.led_cflt = {8{s.blink}};
                end else begin
                    unique case (s.mtype)
                        sls_pkg::MT_DISCRETE_IO_MODULE: begin
                            n.led_act = s.ch_act;
                            n.led_cflt = s.ch_flt | (warn & {8{s.blink}});
                        end
                        sls_pkg::MT_RELAY: begin
                            n.led_act = s.ch_act;
                            n.led_cflt = warn & {8{s.blink}};
                        end
                        sls_pkg::MT_ANALOG: begin
                            n.led_act = s.ch_act | (s.ch_low & {8{s.blink}});
                            n.led_cflt = s.ch_flt | (warn & {8{s.blink}});
                        end
                        sls_pkg::MT_SPARE: n.led_act = 8'h0;
                    endcase
                end
            end
            default: n.led_flt = 1'h1;
        endcase
    end

    // state register; reset only loads constants
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s <= '0;
            s.led_pwr <= sls_pkg::LED_ON;
            s.led_flt <= sls_pkg::LED_ON;
            s.awready <= sls_pkg::RDY_RST;
            s.wready <= sls_pkg::RDY_RST;
            s.arready <= sls_pkg::RDY_RST;
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state register
    assign LED_PWR = s.led_pwr;
    assign LED_FLT = s.led_flt;
    assign LED_ACT = s.led_act;
    assign LED_CFLT = s.led_cflt;
    assign S_AXI_AWREADY = s.awready;
    assign S_AXI_WREADY = s.wready;
    assign S_AXI_BVALID = s.bvalid;
    assign S_AXI_BRESP = s.bresp;
    assign S_AXI_ARREADY = s.arready;
    assign S_AXI_RVALID = s.rvalid;
    assign S_AXI_RDATA = s.rdata;
    assign S_AXI_RRESP = s.rresp;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    property p_pwr_on;
        ##1 LED_PWR;
    endproperty
    a_pwr_on: assert property (p_pwr_on) else $error("power led went dark");

    property p_lamp;
        s.phase == sls_pkg::PH_LAMP |=> LED_PWR && LED_FLT && LED_ACT == 8'h0;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp phase leds wrong");

    property p_red_on;
        s.phase == sls_pkg::PH_RED_ON && s.idx == 3'h3 |=> LED_ACT == 8'h0f && LED_CFLT == 8'h0;
    endproperty
    a_red_on: assert property (p_red_on) else $error("red sweep on pattern wrong");

    property p_red_off;
        s.phase == sls_pkg::PH_RED_OFF && s.idx == 3'h0 |=> LED_ACT == 8'hfe;
    endproperty
    a_red_off: assert property (p_red_off) else $error("red sweep off pattern wrong");

    property p_amb;
        s.phase == sls_pkg::PH_AMB_ON && s.idx == 3'h7 && tmr_end |=> LED_CFLT == 8'hff ##1 LED_CFLT == 8'hfe;
    endproperty
    a_amb: assert property (p_amb) else $error("amber sweep wrong");

    property p_addr_show;
        s.phase == sls_pkg::PH_ADDR |=> LED_ACT == $past(s.addr) && LED_FLT;
    endproperty
    a_addr_show: assert property (p_addr_show) else $error("address not shown");

    // the display timer must step once a cycle and leave only at its last count
    property p_addr_len;
        s.phase == sls_pkg::PH_ADDR |=> (s.phase == sls_pkg::PH_ADDR && s.tmr == $past(s.tmr) + 32'h1)
            || (s.phase == sls_pkg::PH_RUN && $past(s.tmr) == 32'(ADDR_SHOW_CYCLES - 1));
    endproperty
    a_addr_len: assert property (p_addr_len) else $error("address display overran");

    property p_flt_off;
        s.phase == sls_pkg::PH_RUN && !s.dev_dis && !WDOG_FAULT |=> !LED_FLT;
    endproperty
    a_flt_off: assert property (p_flt_off) else $error("device fault led stuck");

    property p_flt_steady;
        s.phase == sls_pkg::PH_RUN && (s.dev_dis || WDOG_FAULT) |=> LED_FLT;
    endproperty
    a_flt_steady: assert property (p_flt_steady) else $error("device fault led not lit");

    property p_unconf;
        s.phase == sls_pkg::PH_RUN && !s.mod_cfg |=> LED_CFLT == {8{$past(s.blink)}};
    endproperty
    a_unconf: assert property (p_unconf) else $error("unconfigured blink wrong");

    property p_disc_red;
        s.phase == sls_pkg::PH_RUN && s.mod_cfg && s.mtype == sls_pkg::MT_DISCRETE_IO_MODULE
            |=> LED_ACT == $past(s.ch_act);
    endproperty
    a_disc_red: assert property (p_disc_red) else $error("discrete red wrong");

    property p_addr_hold;
        s.cap_done |=> $stable(s.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("captured address changed");

    property p_disc_amb;
        s.phase == sls_pkg::PH_RUN && s.mod_cfg && s.mtype == sls_pkg::MT_DISCRETE_IO_MODULE
            |=> (LED_CFLT & $past(s.ch_flt)) == $past(s.ch_flt);
    endproperty
    a_disc_amb: assert property (p_disc_amb) else $error("discrete fault amber not steady");

    // relay channels have no steady amber meaning, so amber may only show a warning
    property p_relay_amb;
        s.phase == sls_pkg::PH_RUN && s.mod_cfg && s.mtype == sls_pkg::MT_RELAY
            |=> (LED_CFLT & ~$past(warn)) == 8'h0;
    endproperty
    a_relay_amb: assert property (p_relay_amb) else $error("relay amber lit without warning");

    property p_ana_red;
        s.phase == sls_pkg::PH_RUN && s.mod_cfg && s.mtype == sls_pkg::MT_ANALOG
            |=> (LED_ACT & $past(s.ch_act)) == $past(s.ch_act) && (LED_ACT & ~$past(s.ch_act | s.ch_low)) == 8'h0;
    endproperty
    a_ana_red: assert property (p_ana_red) else $error("analog alarm red wrong");

    property p_ana_amb;
        s.phase == sls_pkg::PH_RUN && s.mod_cfg && s.mtype == sls_pkg::MT_ANALOG
            |=> (LED_CFLT & $past(s.ch_flt)) == $past(s.ch_flt);
    endproperty
    a_ana_amb: assert property (p_ana_amb) else $error("analog range amber not steady");
endmodule
`default_nettype wire

//--- core/sls_pkg.sv
// package of constants and types for the status led sequencer
`default_nettype none
package sls_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned ADDR_SHOW_MS = 2000;
    localparam int unsigned ADDR_SHOW_CYC = ADDR_SHOW_MS * CYC_PER_MS;
    localparam int unsigned STEP_MS = 125;
    localparam int unsigned STEP_CYC = STEP_MS * CYC_PER_MS;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;

    // geometry
    localparam int unsigned NCH = 8;
    localparam int unsigned AXI_AW = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CH_ACT = 8'h04;
    localparam logic [7:0] OFS_CH_FLT = 8'h08;
    localparam logic [7:0] OFS_CH_LOW = 8'h0c;
    localparam logic [7:0] OFS_CH_CFG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_LEDS = 8'h18;

    // ctrl field positions
    localparam int unsigned CTRL_TYPE_LSB = 0;
    localparam int unsigned CTRL_CFG_BIT = 2;
    localparam int unsigned CTRL_DIS_BIT = 3;
    localparam int unsigned CTRL_LOWPWR_BIT = 4;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // values after reset
    localparam logic RDY_RST = 1'h1;
    localparam logic LED_ON = 1'h1;

    typedef enum logic [2:0] {PH_LAMP, PH_RED_ON, PH_RED_OFF, PH_AMB_ON, PH_AMB_OFF, PH_ADDR, PH_RUN} sls_phase_e;
    typedef enum logic [1:0] {MT_DISCRETE_IO_MODULE, MT_RELAY, MT_ANALOG, MT_SPARE} sls_mtype_e;

    typedef struct packed {
        sls_phase_e phase;
        logic [2:0] idx;
        logic [31:0] tmr;
        logic [31:0] blink_tmr;
        logic blink;
        logic cap_done;
        logic [7:0] addr;
        sls_mtype_e mtype;
        logic mod_cfg;
        logic dev_dis;
        logic low_pwr;
        logic [7:0] ch_act;
        logic [7:0] ch_flt;
        logic [7:0] ch_low;
        logic [7:0] ch_cfg;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wstb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic led_pwr;
        logic led_flt;
        logic [7:0] led_act;
        logic [7:0] led_cflt;
    } sls_state_s;
endpackage
`default_nettype wire

//--- verif/sls_panel_model.sv
// front panel model: address switch bank facing the sequencer
`default_nettype none
module sls_panel_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] sw_set,
    output logic [7:0] addr_sw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] since_q;
    // cycles since reset release, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            since_q <= 4'h0;
        end else if (since_q != 4'hf) begin
            since_q <= since_q + 4'h1;
        end
    end
    // switches are moved soon after release, so a design that keeps reading them shows it
    assign addr_sw = (since_q > 4'h2) ? ~sw_set : sw_set;
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the status led sequencer
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SHOW = 40;
    logic clk, nrst, wdog, led_pwr, led_flt, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] sw_set, addr_sw, led_act, led_cflt, awaddr, araddr;
    logic [31:0] wdata, rdata, seed, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] a;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    sls_top #(.ADDR_SHOW_CYCLES(SHOW), .STEP_CYCLES(4), .BLINK_HALF_CYCLES(3)) i_sls_top (
        .CLK(clk), .NRST(nrst), .ADDR_SW(addr_sw), .WDOG_FAULT(wdog), .LED_PWR(led_pwr), .LED_FLT(led_flt),
        .LED_ACT(led_act), .LED_CFLT(led_cflt), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    sls_panel_model i_sls_panel_model (.clk(clk), .nrst(nrst), .sw_set(sw_set), .addr_sw(addr_sw));
    // clock at 250 MHz
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            test_done();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected panel state k of the power-up walk, as {device amber, amber ch, red ch}
    function automatic logic [16:0] exp_seq(input int k, input logic [7:0] ad);
        logic [7:0] m;
        if (k == 0) return 17'h10000;
        m = 8'hff >> (8 - ((k - 1) % 8 + 1));
        case ((k - 1) / 8)
            0: return {1'b1, 8'h00, m};
            1: return {1'b1, 8'h00, ~m};
            2: return {1'b1, m, 8'h00};
            3: return {1'b1, ~m, 8'h00};
            default: return {1'b1, 8'h00, ad};
        endcase
    endfunction
    // steady and blinking channel leds expected in the run phase
    function automatic void exp_run(input logic [31:0] c, input logic [7:0] act, flt, low, cfg,
                                    output logic [7:0] sr, br, sf, bf);
        logic [7:0] bm;
        bm = (c[4] ? 8'hff : 8'h00) | ~cfg;
        sr = 8'h00;
        br = 8'h00;
        sf = 8'h00;
        bf = 8'h00;
        if (!c[2]) begin
            bf = 8'hff;
        end else if (c[1:0] == 2'h0) begin
            sr = act;
            sf = flt;
            bf = bm & ~flt;
        end else if (c[1:0] == 2'h1) begin
            sr = act;
            bf = bm;
        end else if (c[1:0] == 2'h2) begin
            sr = act;
            br = low & ~act; // steady high alarm wins over the low alarm blink
            sf = flt;
            bf = bm & ~flt;
        end
    endfunction
    // register write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
    endtask
    // register read; rready is held high throughout
    task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        araddr <= ad;
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask
    // reset, then record every change of the panel until the device amber led goes dark
    task automatic power_up(input logic [7:0] ad);
        logic [16:0] v, last;
        logic [16:0] seq[$];
        int dur;
        sw_set <= ad;
        nrst <= 1'b0;
        repeat (11) @(posedge clk);
        #1;
        last = {led_flt, led_cflt, led_act};
        seq = {last};
        dur = 0;
        @(posedge clk);
        nrst <= 1'b1;
        repeat (600) begin
            @(posedge clk);
            #1;
            v = {led_flt, led_cflt, led_act};
            `CHK(led_pwr, 1'b1)
            if (led_flt === 1'b0) break;
            if (v !== last) seq.push_back(v);
            if (seq.size() == 34) dur++;
            last = v;
        end
        @(posedge clk);
        `CHK(seq.size(), 34)
        for (int k = 0; k < seq.size() && k < 34; k++) `CHK(seq[k], exp_seq(k, ad))
        `CHK(dur, SHOW)
        `CHK(led_flt, 1'b0)
        $display("power-up walk done, address %h", ad);
    endtask
    // program one run-phase case and watch the leds across both blink phases
    task automatic run_case(input logic [31:0] c, input logic [7:0] act, flt, low, cfg, input logic wd);
        logic [7:0] aa, oa, af, of, sr, br, sf, bf;
        int mixed;
        axw(sls_pkg::OFS_CTRL, c, 4'hf, rs);
        axw(sls_pkg::OFS_CH_ACT, {24'h0, act}, 4'hf, rs);
        axw(sls_pkg::OFS_CH_FLT, {24'h0, flt}, 4'hf, rs);
        axw(sls_pkg::OFS_CH_LOW, {24'h0, low}, 4'hf, rs);
        axw(sls_pkg::OFS_CH_CFG, {24'h0, cfg}, 4'hf, rs);
        wdog <= wd;
        repeat (3) @(posedge clk);
        {aa, af, oa, of, mixed} = '0;
        {aa, af} = 16'hffff;
        repeat (8) begin
            @(posedge clk);
            #1;
            aa &= led_act;
            oa |= led_act;
            af &= led_cflt;
            of |= led_cflt;
            if (led_cflt !== 8'h00 && led_cflt !== 8'hff) mixed++;
            `CHK(led_flt, c[3] | wd)
        end
        @(posedge clk);
        exp_run(c, act, flt, low, cfg, sr, br, sf, bf);
        `CHK(aa, sr)
        `CHK(oa, sr | br)
        `CHK(af, sf)
        `CHK(of, sf | bf)
        if (!c[2]) `CHK(mixed, 0)
        $display("run case ctrl %h done", c[4:0]);
    endtask
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {nrst, wdog, awvalid, wvalid, arvalid, sw_set, awaddr, araddr, wdata, wstrb} = '0;
        bready = 1'b1;
        rready = 1'b1;
        seed = 32'h7a86;
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            a = seed[7:0] | 8'h10; // a zero address would be invisible in the change log
            power_up(a);
            axr(sls_pkg::OFS_CTRL, rd, rs);
            `CHK(rd, 32'h0)
            axr(sls_pkg::OFS_STATUS, rd, rs);
            `CHK(rd, {20'h0, 1'b1, a, 3'h6})
            // amber channel bits follow the free blink, so only the steady bits are compared
            axr(sls_pkg::OFS_LEDS, rd, rs);
            `CHK(rd & 32'hffff_00ff, 32'h0002_0000)
            axw(sls_pkg::OFS_STATUS, 32'hffff_ffff, 4'hf, rs);
            `CHK(rs, sls_pkg::RESP_OKAY)
            axr(8'h1c, rd, rs);
            `CHK({rs, rd}, {sls_pkg::RESP_SLVERR, 32'h0})
            axw(8'h20, 32'h1f, 4'hf, rs);
            `CHK(rs, sls_pkg::RESP_SLVERR)
            axw(sls_pkg::OFS_CTRL, seed, 4'hf, rs);
            axw(sls_pkg::OFS_CTRL, ~seed, 4'he, rs);
            axr(sls_pkg::OFS_CTRL, rd, rs);
            `CHK(rd, seed & 32'h1f)
            for (int i = 0; i < 8; i++) begin
                seed = lfsr(lfsr(seed));
                // cases 5, 6 and 7 always hit watchdog, disabled and unconfigured
                run_case({seed[31:4], (seed[3] & seed[8]) | (i == 6), (i < 4) | (seed[2] & (i != 7)), i[1:0]},
                         seed[15:8], seed[23:16], seed[31:24], seed[7:0] | seed[19:12], seed[9] | (i == 5));
            end
            wdog <= 1'b0;
        end
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire
